/* awp_assertions.sv */
// Purpose: Port timing checker for the word packetizer.
// Assumes: Bound to awp_packetizer; one clock domain.
// Notes:   Packet contents are judged by the bench.
`timescale 1ns/1ps
`default_nettype none
module awp_checker (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        word_ready,
	input wire logic        pkt_valid,
	input wire logic        pkt_ready,
	input wire logic [15:0] pkt_data,
	input wire logic        pkt_first,
	input wire logic        pkt_last,
	input wire logic        irq
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	sync_lead_a: assert property (pkt_valid && pkt_first |-> pkt_data == 16'heb25)
		else $error("sync half wrong");
	open_first_a: assert property ($rose(pkt_valid) |-> pkt_first)
		else $error("packet opened without sync");
	half_hold_a: assert property (pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_data))
		else $error("half dropped while stalled");
	last_close_a: assert property (pkt_valid && pkt_ready && pkt_last |=> !pkt_valid)
		else $error("valid after last half");
	apb_answer_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer late");
	apb_pulse_a: assert property (pready |=> !pready)
		else $error("apb ready too long");
	bad_addr_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08,
		8'h0c, 8'h10})) else $error("apb error flag wrong");
	rst_quiet_a: assert property ($fell(reset) |-> !pkt_valid && !word_ready && !irq && !pready)
		else $error("outputs busy after reset");
	cover property (pkt_valid && pkt_ready && pkt_last);
	cover property (pready && pslverr);
	cover property (irq);
endmodule : awp_checker
bind awp_packetizer awp_checker chk_u (.sys_clk, .reset, .psel, .penable, .paddr, .pready,
	.pslverr, .word_ready, .pkt_valid, .pkt_ready, .pkt_data, .pkt_first, .pkt_last, .irq);
`default_nettype wire

/* awp_packetizer.sv */
// Purpose: Packs received bus words, each behind an ID word, into 16-bit packet halves.
// Assumes: Receivers share sys_clk; APB slave for control and status.
// Notes:   Packets are buffered whole since the word count precedes the words.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "awp_params.svh"

module awp_packetizer #(
	parameter int DEPTH = 256
) (
	input  wire logic              sys_clk,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire logic              word_valid,
	output logic                   word_ready,
	input  wire logic [31:0]       word_data,
	input  wire logic [7:0]        word_bus,
	input  wire logic              format_error_flag,
	input  wire logic              parity_error_flag,
	input  wire logic              bus_rate_select,
	input  wire awp_pkg::awp_time_t word_time,
	output logic                   pkt_valid,
	input  wire logic              pkt_ready,
	output logic [15:0]            pkt_data,
	output logic                   pkt_first,
	output logic                   pkt_last,
	output logic                   irq
);
	import awp_pkg::*;

	localparam int AW = $clog2(DEPTH);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] make_id(input logic [7:0] bus, input logic fe,
			input logic pe, input logic rs, input logic [`AWP_GAP_W-1:0] gap);
		logic [31:0] id;
		id = 32'h0;
		id[31:`AWP_ID_BUS_LSB] = bus;
		id[`AWP_ID_FMT_BIT] = fe;
		id[`AWP_ID_PAR_BIT] = pe;
		id[`AWP_ID_RATE_BIT] = rs;
		id[`AWP_ID_RSVD_BIT] = 1'b0;
		id[`AWP_GAP_W-1:0] = gap;
		return id;
	endfunction : make_id

	function automatic logic [15:0] half_of(input logic [31:0] w, input logic hi);
		return hi ? w[31:16] : w[15:0];
	endfunction : half_of

	// ****************************************
	// State
	// ****************************************
	awp_state_t        state_r;
	logic [63:0]       entry_mem [DEPTH];
	logic [15:0]       cnt_r;
	awp_time_t         ptime_r;
	logic              en_r;
	logic              flush_r;
	logic [15:0]       maxw_r;
	logic [`AWP_EV_W-1:0] stat_r;
	logic [`AWP_EV_W-1:0] mask_r;
	logic [4:0]        tick_r;
	logic [`AWP_GAP_W-1:0] gap_r;
	logic              gap_over_r;
	logic              hold_r;
	logic [63:0]       hold_word_r;
	awp_time_t         hold_time_r;
	logic [2:0]        hdr_r;
	logic [15:0]       ent_r;
	logic [1:0]        part_r;
	logic [15:0]       limit_w;
	logic              acc;
	logic              split;
	logic [15:0]       cnt_nxt;
	logic              go_send;
	logic              out_adv;
	logic              last_half;
	logic [15:0]       half_nxt;
	logic              apb_wr;
	logic              apb_rd;

	assign acc     = word_valid && word_ready;
	assign split   = acc && (cnt_r != 16'h0) && gap_over_r;
	assign cnt_nxt = cnt_r + {15'h0, acc && !split};
	assign limit_w = (maxw_r == 16'h0 || maxw_r > 16'(DEPTH)) ? 16'(DEPTH) : maxw_r;
	assign go_send = (state_r == AWP_COLLECT)
		&& (split || cnt_nxt >= limit_w || (flush_r && cnt_nxt != 16'h0));
	assign out_adv = !pkt_valid || pkt_ready;
	assign last_half = (hdr_r == `AWP_HDR_HALVES) && (ent_r == cnt_r - 16'h1)
		&& (part_r == 2'd3);
	assign apb_wr = psel && penable && pwrite && !pready;
	assign apb_rd = psel && penable && !pwrite && !pready;

	// ****************************************
	// Gap timing
	// ****************************************
	// Saturates so a long silence cannot wrap into a small gap
	always_ff @(posedge sys_clk) begin
		if (reset || acc) begin
			tick_r <= 5'h0;
			gap_r  <= '0;
		end else if (tick_r == 5'(`AWP_GAP_TICK_CYC - 1)) begin
			tick_r <= 5'h0;
			if (gap_r != '1)
				gap_r <= gap_r + 1'b1;
		end else begin
			tick_r <= tick_r + 5'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || acc)
			gap_over_r <= 1'b0;
		else if (gap_r > `AWP_GAP_W'(`AWP_GAP_LIMIT))
			gap_over_r <= 1'b1;
	end

	// ****************************************
	// Word capture
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (acc && !split) begin
			entry_mem[cnt_r[AW-1:0]] <= {word_data, make_id(word_bus, format_error_flag,
				parity_error_flag, bus_rate_select,
				(cnt_r == 16'h0) ? `AWP_GAP_W'(0) : gap_r)};
		end else if (state_r == AWP_SEND && hold_r && out_adv && last_half) begin
			entry_mem[0] <= hold_word_r;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hold_r      <= 1'b0;
			hold_word_r <= 64'h0;
			hold_time_r <= '0;
		end else if (split) begin
			hold_r      <= 1'b1;
			hold_word_r <= {word_data, make_id(word_bus, format_error_flag,
				parity_error_flag, bus_rate_select, `AWP_GAP_W'(0))};
			hold_time_r <= word_time;
		end else if (state_r == AWP_SEND && out_adv && last_half) begin
			hold_r <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ptime_r <= '0;
		end else if (acc && !split && cnt_r == 16'h0) begin
			ptime_r <= word_time;
		end else if (state_r == AWP_SEND && hold_r && out_adv && last_half) begin
			ptime_r <= hold_time_r;
		end
	end

	// ****************************************
	// Packet sequencing
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r    <= AWP_COLLECT;
			cnt_r      <= 16'h0;
			word_ready <= 1'b0;
		end else if (state_r == AWP_COLLECT) begin
			cnt_r      <= cnt_nxt;
			word_ready <= en_r && !go_send && !hold_r;
			if (go_send)
				state_r <= AWP_SEND;
		end else if (out_adv && last_half) begin
			state_r    <= AWP_COLLECT;
			cnt_r      <= hold_r ? 16'h1 : 16'h0;
			word_ready <= en_r;
		end
	end

	always_comb begin
		half_nxt = `AWP_SYNC;
		unique case (hdr_r)
			3'd0: half_nxt = `AWP_SYNC;
			3'd1: half_nxt = ptime_r[15:0];
			3'd2: half_nxt = ptime_r[31:16];
			3'd3: half_nxt = ptime_r[47:32];
			3'd4: half_nxt = cnt_r;
			3'd5: half_nxt = 16'h0;
			default: begin
				if (part_r[1])
					half_nxt = half_of(entry_mem[ent_r[AW-1:0]][63:32], part_r[0]);
				else
					half_nxt = half_of(entry_mem[ent_r[AW-1:0]][31:0], part_r[0]);
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			hdr_r     <= 3'd0;
			ent_r     <= 16'h0;
			part_r    <= 2'd0;
			pkt_valid <= 1'b0;
			pkt_data  <= 16'h0;
			pkt_first <= 1'b0;
			pkt_last  <= 1'b0;
		end else if (out_adv) begin
			pkt_valid <= state_r == AWP_SEND;
			pkt_data  <= half_nxt;
			pkt_first <= state_r == AWP_SEND && hdr_r == 3'd0;
			pkt_last  <= state_r == AWP_SEND && last_half;
			if (state_r == AWP_SEND) begin
				if (last_half) begin
					hdr_r  <= 3'd0;
					ent_r  <= 16'h0;
					part_r <= 2'd0;
				end else if (hdr_r != `AWP_HDR_HALVES) begin
					hdr_r <= hdr_r + 3'd1;
				end else begin
					part_r <= part_r + 2'd1;
					if (part_r == 2'd3)
						ent_r <= ent_r + 16'h1;
				end
			end
		end
	end

	// ****************************************
	// Registers and interrupt
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			en_r    <= `AWP_CTRL_RST;
			flush_r <= 1'b0;
			mask_r  <= `AWP_MASK_RST;
			maxw_r  <= `AWP_MAXW_RST;
		end else begin
			flush_r <= 1'b0;
			if (apb_wr && paddr == `AWP_CTRL_ADDR) begin
				en_r    <= pwdata[`AWP_CTRL_EN_BIT];
				flush_r <= pwdata[`AWP_CTRL_FLUSH_BIT];
			end
			if (apb_wr && paddr == `AWP_MASK_ADDR)
				mask_r <= pwdata[`AWP_EV_W-1:0];
			if (apb_wr && paddr == `AWP_MAXW_ADDR)
				maxw_r <= pwdata[15:0];
		end
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~((apb_wr && paddr == `AWP_STAT_ADDR)
				? pwdata[`AWP_EV_W-1:0] : '0))
				| {acc && (format_error_flag || parity_error_flag), split,
				state_r == AWP_SEND && out_adv && last_half};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(stat_r & mask_r);
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready  <= 1'b0;
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_wr || apb_rd;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
			if (apb_wr || apb_rd) begin
				unique case (paddr)
					`AWP_CTRL_ADDR: prdata <= {31'h0, en_r};
					`AWP_STAT_ADDR: prdata <= {29'h0, stat_r};
					`AWP_MASK_ADDR: prdata <= {29'h0, mask_r};
					`AWP_INFO_ADDR: prdata <= {14'h0, hold_r, state_r == AWP_SEND, cnt_r};
					`AWP_MAXW_ADDR: prdata <= {16'h0, maxw_r};
					default:        pslverr <= 1'b1;
				endcase
			end
		end
	end

endmodule : awp_packetizer

`default_nettype wire

/* awp_params.svh */
// Purpose: Constants for the bus word packetizer: offsets, fields, resets, timing.
// Assumes: 200 MHz system clock, APB register access with 32-bit data.
// Notes:   Included by the packetizer; definitions only.
`ifndef AWP_PARAMS_SVH
`define AWP_PARAMS_SVH

// ****************************************
// Register byte addresses
// ****************************************
`define AWP_CTRL_ADDR       8'h00
`define AWP_STAT_ADDR       8'h04
`define AWP_MASK_ADDR       8'h08
`define AWP_INFO_ADDR       8'h0c
`define AWP_MAXW_ADDR       8'h10

// ****************************************
// Control and status fields
// ****************************************
`define AWP_CTRL_EN_BIT     0
`define AWP_CTRL_FLUSH_BIT  1
`define AWP_EV_DONE_BIT     0
`define AWP_EV_SPLIT_BIT    1
`define AWP_EV_ERR_BIT      2
`define AWP_EV_W            3

// ****************************************
// Reset values
// ****************************************
`define AWP_CTRL_RST        1'b0
`define AWP_MASK_RST        3'h0
`define AWP_MAXW_RST        16'h0100

// ****************************************
// Packet and word layout
// ****************************************
`define AWP_SYNC            16'heb25
`define AWP_ID_BUS_LSB      24
`define AWP_ID_FMT_BIT      23
`define AWP_ID_PAR_BIT      22
`define AWP_ID_RATE_BIT     21
`define AWP_ID_RSVD_BIT     20
`define AWP_GAP_W           20
`define AWP_HDR_HALVES      3'd6

// ****************************************
// Timing
// ****************************************
`define AWP_CLK_PERIOD_PS   5000
`define AWP_GAP_STEP_PS     100000
`define AWP_GAP_TICK_CYC    (`AWP_GAP_STEP_PS / `AWP_CLK_PERIOD_PS)
`define AWP_GAP_LIMIT_MS    100
`define AWP_GAP_STEPS_PER_MS 10000
`define AWP_GAP_LIMIT       (`AWP_GAP_LIMIT_MS * `AWP_GAP_STEPS_PER_MS)

`endif

/* awp_pkg.sv */
// Purpose: Types shared by the bus word packetizer.
// Assumes: Constants come from awp_params.svh.
// Notes:   Types only.
package awp_pkg;

	typedef enum logic {
		AWP_COLLECT,
		AWP_SEND
	} awp_state_t;

	typedef logic [47:0] awp_time_t;

endpackage : awp_pkg

/* awp_sink.sv */
// Purpose: Stream sink that drives pkt_ready for packet halves.
// Assumes: Shares sys_clk with the packetizer.
// Notes:   Slow mode stalls at random to stress half holding.
`timescale 1ns/1ps
`default_nettype none
module awp_sink (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic slow,
	output logic     pkt_ready
);
	int seed = 98;
	always_ff @(posedge sys_clk) begin
		pkt_ready <= !reset && (!slow || $random(seed) % 2 == 0);
	end
endmodule : awp_sink
`default_nettype wire

/* tb_arinc429_word_packetizer.sv */
// Purpose: Self-checking bench for the word packetizer.
// Assumes: 200 MHz clock; gap ticks every 20 cycles from each accept.
// Notes:   Gap split needs 20M cycles, left to long runs.
`timescale 1ns/1ps
`default_nettype none
module tb_arinc429_word_packetizer;
	import awp_pkg::*;
	logic        sys_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
	logic        word_valid = 0, format_error_flag = 0, parity_error_flag = 0;
	logic        bus_rate_select = 0, pready, pslverr, word_ready, pkt_valid, pkt_ready;
	logic        pkt_first, pkt_last, irq;
	logic [7:0]  paddr = 8'h00, word_bus = 8'h00;
	logic [31:0] pwdata = 32'h0, word_data = 32'h0, prdata;
	logic [15:0] pkt_data;
	awp_time_t   word_time = '0, t0;
	logic [15:0] exp_q[$];
	logic [31:0] ids[$], dat[$];
	int          num_errors = 0, tests_run = 0, seed = 98, cyc = 0, last = 0, nw = 0;
	int          hpos = 0;

	awp_packetizer dut_u (.*);
	awp_sink sink_u (.sys_clk, .reset, .slow, .pkt_ready);

	initial forever #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) cyc <= cyc + 1;

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test

	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wait_hi(ref logic s);
		int i;
		i = 0;
		do begin @(posedge sys_clk); i++; end while (s !== 1'b1 && i < 200);
		if (i >= 200) begin num_errors++; end_of_test(); end
	endtask : wait_hi

	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, output logic [31:0] rd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		wait_hi(pready);
		rd = prdata;
		chk("apb error", 32'(!(a inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10})), 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb

	task automatic send(int idle);
		logic [31:0] d;
		logic [7:0]  b;
		logic [2:0]  f;
		awp_time_t   t;
		repeat (idle) @(posedge sys_clk);
		d = $random(seed);
		b = 8'($random(seed));
		f = 3'(nw);
		t = {16'($random(seed)), 32'($random(seed))};
		word_valid <= 1'b1;
		word_data <= d;
		word_bus <= b;
		{format_error_flag, parity_error_flag, bus_rate_select} <= f;
		word_time <= t;
		wait_hi(word_ready);
		word_valid <= 1'b0;
		if (ids.size() == 0) t0 = t;
		ids.push_back({b, f, 1'b0, ids.size() == 0 ? 20'h0 : 20'((cyc - last) / 20)});
		dat.push_back(d);
		last = cyc;
		nw++;
	endtask : send

	task automatic flush();
		logic [31:0] rd;
		int i;
		exp_q.push_back(16'heb25);
		for (i = 0; i < 3; i++) exp_q.push_back(t0[16*i +: 16]);
		exp_q.push_back(16'(ids.size()));
		exp_q.push_back(16'h0000);
		foreach (ids[j]) begin
			exp_q.push_back(ids[j][15:0]);
			exp_q.push_back(ids[j][31:16]);
			exp_q.push_back(dat[j][15:0]);
			exp_q.push_back(dat[j][31:16]);
		end
		ids.delete();
		dat.delete();
		apb(1'b1, 8'h00, 32'h3, rd);
		i = 0;
		while (exp_q.size() != 0 && i < 3000) begin @(posedge sys_clk); i++; end
		if (i >= 3000) begin num_errors++; end_of_test(); end
		repeat (4) @(posedge sys_clk);
		$display("packet test done, words %0d", nw);
	endtask : flush

	// Halves are compared in arrival order against exp_q
	always @(posedge sys_clk) begin
		if (!reset && pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
			if (exp_q.size() == 0) chk("extra half", 32'h0, 32'h1);
			else begin
				chk("first flag", 32'(hpos == 0), 32'(pkt_first));
				chk("last flag", 32'(exp_q.size() == 1), 32'(pkt_last));
				hpos = (exp_q.size() == 1) ? 0 : hpos + 1;
				chk("packet half", 32'(exp_q.pop_front()), {16'h0, pkt_data});
			end
		end
	end

	initial begin
		logic [31:0] rd;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		apb(1'b0, 8'h14, 32'h0, rd);
		apb(1'b0, 8'h10, 32'h0, rd);
		chk("word limit", 32'h100, rd);
		apb(1'b1, 8'h08, 32'h1, rd);
		apb(1'b1, 8'h00, 32'h1, rd);
		// Spacing of 20n+10 cycles keeps gaps clear of tick edges
		send(0);
		send(29);
		send(49);
		send(209);
		flush();
		apb(1'b0, 8'h04, 32'h0, rd);
		chk("status", 32'h5, rd);
		chk("irq set", 32'h1, 32'(irq));
		apb(1'b1, 8'h04, 32'h7, rd);
		repeat (3) @(posedge sys_clk);
		chk("irq clear", 32'h0, 32'(irq));
		slow <= 1'b1;
		send(0);
		send(9);
		send(49);
		send(29);
		flush();
		end_of_test();
	end
endmodule : tb_arinc429_word_packetizer
`default_nettype wire
